// *** abr_defs.vh ***
// Constants for the abort register fix-up block.
// Assumes inclusion by bare name from the fix-up design files.
`ifndef ABR_DEFS_VH
`define ABR_DEFS_VH

// =====================================================
// Upper opcode bytes, and one upper nibble for call relative
`define ABR_OP_TRANSLATE   8'hB8
`define ABR_OP_BSTRING     8'hBA
`define ABR_OP_WSTRING     8'hBB
`define ABR_OP_CALL_IR     8'h1F
`define ABR_OP_CALL_X      8'h5F
`define ABR_OP_CALR_HI     4'hD
`define ABR_OP_PUSHL_IR    8'h11
`define ABR_OP_PUSHL_X     8'h51
`define ABR_OP_LDL_IR      8'h14
`define ABR_OP_LDL_BA      8'h35
`define ABR_OP_LDL_BX      8'h75
`define ABR_OP_LOAD_PROGRAM_STATUS        8'h39
`define ABR_OP_RET         8'h9E
`define ABR_OP_LDM_IR      8'h10
`define ABR_OP_LDM_X       8'h50

// =====================================================
// Low opcode nibbles of string instructions
`define ABR_LN_LD_INC      4'h1
`define ABR_LN_CP_INC_A    4'h2
`define ABR_LN_CP_INC_B    4'h6
`define ABR_LN_LD_DEC      4'h9
`define ABR_LN_CP_DEC_A    4'hA
`define ABR_LN_CP_DEC_B    4'hE

// =====================================================
// Transfer counter values
`define ABR_RW_NONE        4'h0
`define ABR_RW_ONE         4'h1
`define ABR_RW_TWO         4'h2
`define ABR_RW_THREE       4'h3

// =====================================================
// Steps and fixed words
`define ABR_STEP_ONE       16'h0001
`define ABR_STEP_TWO       16'h0002
`define ABR_STEP_FOUR      16'h0004
`define ABR_FCW_NONSEG_SYS 16'h4000
`define ABR_FCW_SEG_SYS    16'hC000
`define ABR_ZERO16         16'h0000
`define ABR_ZERO8          8'h00
`define ABR_SEG_PAD        1'h0
`define ABR_IDX_NONE       4'h0

`endif

// *** abr_fixup.v ***
// Register fix-up after a memory-management abort.
// Assumes register values and MMU capture arrive from logic on
// core_clk_in; corrected values are written back on the we pulses.
//
// Functional notes
// - Translate and byte string opcodes add one to the count register.
// - Call opcodes add four to the stack offset if segmented, else two.
// - Byte auto-increment load with pending write steps dest back one.
// - Byte auto-increment compare with source mismatch steps dest back.
// - Byte auto-decrement load with pending write steps dest up one.
// - Byte auto-decrement compare with source mismatch steps dest up.
// - Word strings restore the count and use a pointer step of two.
// - Push long with transfer count three adds four to the dest pointer.
// - Load long indirect or base with count one restores the address.
// - Load long base index, segmented, restores the segment number.
// - Load program status rewrites the saved flag-control word.
// - Return backs the stack offset by two or four on the read count.
// - Load multiple indirect rebuilds the address register, or the pair if segmented.
// - Load multiple index rebuilds the index register.
`timescale 1ns/10ps
`default_nettype none
`include "abr_defs.vh"

module abr_fixup
(
  // Clock, reset, enable
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  // Sequencing
  input  wire        start_in,
  input  wire        restart_in,
  // Instruction decode
  input  wire [7:0]  opcode_hi_in,
  input  wire [3:0]  low_opcode_nibble_in,
  input  wire        segmented_flag_in,
  input  wire        dest_is_addr_reg_in,
  input  wire [3:0]  index_sel_in,
  input  wire [4:0]  ldm_read_count_in,
  // MMU capture
  input  wire [3:0]  xfer_count_in,
  input  wire [6:0]  violation_segment_in,
  input  wire [15:0] violation_offset_in,
  input  wire [15:0] instruction_offset_in,
  // Register file snapshot
  input  wire [15:0] count_reg_in,
  input  wire [15:0] stack_offset_reg_in,
  input  wire [15:0] dest_reg_in,
  input  wire [15:0] dest_odd_reg_in,
  input  wire [15:0] source_reg_in,
  input  wire [31:0] source_pair_in,
  input  wire [15:0] flag_control_word_in,
  input  wire [15:0] first_status_word_in,
  // Corrected values
  output reg  [15:0] count_reg_out,
  output reg         count_we_out,
  output reg  [15:0] stack_offset_reg_out,
  output reg         stack_we_out,
  output reg  [15:0] dest_reg_out,
  output reg         dest_we_out,
  output reg  [15:0] dest_odd_reg_out,
  output reg         dest_odd_we_out,
  output reg  [15:0] source_reg_out,
  output reg         source_we_out,
  output reg  [15:0] source_odd_reg_out,
  output reg         source_odd_we_out,
  output reg  [15:0] flag_control_word_out,
  output reg         fcw_we_out,
  // Status
  output reg         done_out,
  output reg         busy_out
);

  // =====================================================
  // States
  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  reg         state_ff;
  reg         nxt_state;

  // =====================================================
  // Shared decode
  wire        segmented_flag;
  wire        byte_str;
  wire        word_str;
  wire [15:0] violation_segment_word;
  wire [31:0] violation_address_pair;
  wire        mismatch;
  wire        write_pending;
  wire        str_hit;
  wire        str_decr;
  wire [15:0] str_step;
  wire [15:0] ldm_ind;
  wire [15:0] ldm_idx;
  wire        apply;

  assign segmented_flag        = segmented_flag_in;
  assign byte_str   = (opcode_hi_in == `ABR_OP_BSTRING);
  assign word_str   = (opcode_hi_in == `ABR_OP_WSTRING);
  assign violation_segment_word  = {`ABR_SEG_PAD, violation_segment_in, `ABR_ZERO8};
  assign violation_address_pair = {violation_segment_word, violation_offset_in};
  assign mismatch   = segmented_flag ? (source_pair_in != violation_address_pair)
                          : (source_reg_in != violation_offset_in);
  assign write_pending = (xfer_count_in == `ABR_RW_NONE);
  assign apply      = ce_in && start_in && (state_ff == ST_IDLE);

  // =====================================================
  // String pointer selector
  abr_str_fix u_str
  (
    .nibble_in        (low_opcode_nibble_in),
    .write_pending_in (write_pending),
    .mismatch_in      (mismatch),
    .word_in          (word_str),
    .hit_out          (str_hit),
    .decr_out         (str_decr),
    .step_out         (str_step)
  );

  // =====================================================
  // Load multiple address rebuild, indirect and index
  abr_ldm_off u_ldm_ind
  (
    .violation_offset_in   (violation_offset_in),
    .instruction_offset_in (instruction_offset_in),
    .read_count_in         (ldm_read_count_in),
    .use_instruction_offset_in           (1'b0),
    .result_out            (ldm_ind)
  );

  abr_ldm_off u_ldm_idx
  (
    .violation_offset_in   (violation_offset_in),
    .instruction_offset_in (instruction_offset_in),
    .read_count_in         (ldm_read_count_in),
    .use_instruction_offset_in           (1'b1),
    .result_out            (ldm_idx)
  );

  // =====================================================
  // Next values
  reg [15:0] nxt_count;
  reg        nxt_count_we;
  reg [15:0] nxt_stack;
  reg        nxt_stack_we;
  reg [15:0] nxt_dest;
  reg        nxt_dest_we;
  reg [15:0] nxt_dodd;
  reg        nxt_dodd_we;
  reg [15:0] nxt_src;
  reg        nxt_src_we;
  reg [15:0] nxt_sodd;
  reg        nxt_sodd_we;
  reg [15:0] nxt_fcw;
  reg        nxt_fcw_we;

  always @*
  begin
    nxt_count    = count_reg_in;
    nxt_count_we = 1'b0;
    nxt_stack    = stack_offset_reg_in;
    nxt_stack_we = 1'b0;
    nxt_dest     = dest_reg_in;
    nxt_dest_we  = 1'b0;
    nxt_dodd     = dest_odd_reg_in;
    nxt_dodd_we  = 1'b0;
    nxt_src      = source_reg_in;
    nxt_src_we   = 1'b0;
    nxt_sodd     = source_pair_in[15:0];
    nxt_sodd_we  = 1'b0;
    nxt_fcw      = flag_control_word_in;
    nxt_fcw_we   = 1'b0;
    if (opcode_hi_in[7:4] == `ABR_OP_CALR_HI)
    begin
      nxt_stack_we = 1'b1;
      nxt_stack    = stack_offset_reg_in +
                     (segmented_flag ? `ABR_STEP_FOUR : `ABR_STEP_TWO);
    end
    else
    begin
      case (opcode_hi_in)
        `ABR_OP_TRANSLATE:
        begin
          nxt_count_we = 1'b1;
          nxt_count    = count_reg_in + `ABR_STEP_ONE;
        end
        `ABR_OP_BSTRING, `ABR_OP_WSTRING:
        begin
          nxt_count_we = 1'b1;
          nxt_count    = count_reg_in + `ABR_STEP_ONE;
          if (str_hit && segmented_flag)
          begin
            nxt_dodd_we = 1'b1;
            nxt_dodd    = str_decr ? dest_odd_reg_in - str_step
                                   : dest_odd_reg_in + str_step;
          end
          else if (str_hit)
          begin
            nxt_dest_we = 1'b1;
            nxt_dest    = str_decr ? dest_reg_in - str_step
                                   : dest_reg_in + str_step;
          end
        end
        `ABR_OP_CALL_IR, `ABR_OP_CALL_X:
        begin
          nxt_stack_we = 1'b1;
          nxt_stack    = stack_offset_reg_in +
                         (segmented_flag ? `ABR_STEP_FOUR : `ABR_STEP_TWO);
        end
        `ABR_OP_PUSHL_IR, `ABR_OP_PUSHL_X:
        begin
          if (xfer_count_in == `ABR_RW_THREE && segmented_flag)
          begin
            nxt_dodd_we = 1'b1;
            nxt_dodd    = dest_odd_reg_in + `ABR_STEP_FOUR;
          end
          else if (xfer_count_in == `ABR_RW_THREE)
          begin
            nxt_dest_we = 1'b1;
            nxt_dest    = dest_reg_in + `ABR_STEP_FOUR;
          end
        end
        `ABR_OP_LDL_IR, `ABR_OP_LDL_BA:
        begin
          if (xfer_count_in == `ABR_RW_ONE)
          begin
            nxt_dest_we = 1'b1;
            nxt_dest    = segmented_flag ? violation_segment_word
                              : violation_offset_in - `ABR_STEP_TWO;
          end
        end
        `ABR_OP_LDL_BX:
        begin
          if (xfer_count_in == `ABR_RW_ONE && segmented_flag &&
              dest_is_addr_reg_in)
          begin
            nxt_dest_we = 1'b1;
            nxt_dest    = violation_segment_word;
          end
        end
        `ABR_OP_LOAD_PROGRAM_STATUS:
        begin
          if (xfer_count_in == `ABR_RW_ONE &&
              flag_control_word_in == first_status_word_in)
          begin
            nxt_fcw_we = 1'b1;
            nxt_fcw    = `ABR_FCW_NONSEG_SYS;
          end
          else if (xfer_count_in == `ABR_RW_TWO)
          begin
            nxt_fcw_we = 1'b1;
            nxt_fcw    = `ABR_FCW_SEG_SYS;
          end
        end
        `ABR_OP_RET:
        begin
          if (xfer_count_in == `ABR_RW_NONE && !segmented_flag)
          begin
            nxt_stack_we = 1'b1;
            nxt_stack    = stack_offset_reg_in - `ABR_STEP_TWO;
          end
          else if (xfer_count_in == `ABR_RW_ONE)
          begin
            nxt_stack_we = 1'b1;
            nxt_stack    = stack_offset_reg_in - `ABR_STEP_FOUR;
          end
        end
        `ABR_OP_LDM_IR:
        begin
          if (segmented_flag)
          begin
            nxt_src_we  = 1'b1;
            nxt_src     = violation_segment_word;
            nxt_sodd_we = 1'b1;
            nxt_sodd    = ldm_ind;
          end
          else
          begin
            nxt_src_we  = 1'b1;
            nxt_src     = ldm_ind;
          end
        end
        `ABR_OP_LDM_X:
        begin
          if (index_sel_in != `ABR_IDX_NONE)
          begin
            nxt_src_we = 1'b1;
            nxt_src    = ldm_idx;
          end
        end
        default:
        begin
          nxt_count_we = 1'b0;
        end
      endcase
    end
  end

  // =====================================================
  // Sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_in)
        begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (restart_in)
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // =====================================================
  // Output registers
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      state_ff              <= ST_IDLE;
      count_reg_out         <= `ABR_ZERO16;
      count_we_out          <= 1'b0;
      stack_offset_reg_out  <= `ABR_ZERO16;
      stack_we_out          <= 1'b0;
      dest_reg_out          <= `ABR_ZERO16;
      dest_we_out           <= 1'b0;
      dest_odd_reg_out      <= `ABR_ZERO16;
      dest_odd_we_out       <= 1'b0;
      source_reg_out        <= `ABR_ZERO16;
      source_we_out         <= 1'b0;
      source_odd_reg_out    <= `ABR_ZERO16;
      source_odd_we_out     <= 1'b0;
      flag_control_word_out <= `ABR_ZERO16;
      fcw_we_out            <= 1'b0;
      done_out              <= 1'b0;
      busy_out              <= 1'b0;
    end
    else if (ce_in)
    begin
      state_ff          <= nxt_state;
      busy_out          <= (nxt_state == ST_HOLD);
      done_out          <= apply;
      count_we_out      <= apply && nxt_count_we;
      stack_we_out      <= apply && nxt_stack_we;
      dest_we_out       <= apply && nxt_dest_we;
      dest_odd_we_out   <= apply && nxt_dodd_we;
      source_we_out     <= apply && nxt_src_we;
      source_odd_we_out <= apply && nxt_sodd_we;
      fcw_we_out        <= apply && nxt_fcw_we;
      if (apply)
      begin
        count_reg_out         <= nxt_count;
        stack_offset_reg_out  <= nxt_stack;
        dest_reg_out          <= nxt_dest;
        dest_odd_reg_out      <= nxt_dodd;
        source_reg_out        <= nxt_src;
        source_odd_reg_out    <= nxt_sodd;
        flag_control_word_out <= nxt_fcw;
      end
    end
  end

endmodule
`default_nettype wire

// *** abr_fixup_monitor.sv ***
// Checker for the abort register fix-up block ports.
// Assumes it is bound to abr_fixup, one clock domain.
`timescale 1ns/10ps
`default_nettype none

module abr_fixup_monitor
(
  // Clock, reset, sequencing
  input wire logic        core_clk_in, rst_in, ce_in, start_in, restart_in,
  // Decode and snapshot
  input wire logic        segmented_flag_in,
  input wire logic [7:0]  opcode_hi_in,
  input wire logic [3:0]  xfer_count_in,
  input wire logic [15:0] violation_offset_in, count_reg_in,
  input wire logic [15:0] stack_offset_reg_in, dest_odd_reg_in,
  // Corrected values
  input wire logic [15:0] count_reg_out, stack_offset_reg_out,
  input wire logic [15:0] dest_reg_out, dest_odd_reg_out,
  input wire logic [15:0] flag_control_word_out,
  input wire logic        count_we_out, stack_we_out, dest_we_out,
  input wire logic        dest_odd_we_out, source_we_out, fcw_we_out,
  input wire logic        done_out, busy_out
);
  // ==========================================================
  // Sequences
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_take;
    ce_in && start_in && !busy_out;
  endsequence
  sequence s_op(op);
    s_take ##0 opcode_hi_in == op;
  endsequence

  // ==========================================================
  // Assertions
  take_answer_a: assert property (s_take |=> done_out && busy_out)
    else $error("start not answered");
  answer_once_a: assert property (done_out && ce_in |=> !done_out)
    else $error("done longer than one cycle");
  hold_busy_a: assert property (busy_out && !restart_in |=> busy_out)
    else $error("busy dropped without restart");
  count_step_a: assert property (s_take ##0 opcode_hi_in inside
    {8'hB8, 8'hBA, 8'hBB} |=> count_we_out
    && count_reg_out == $past(count_reg_in) + 16'h0001)
    else $error("count not restored");
  call_step_a: assert property (s_op(8'h1F) |=> stack_we_out
    && stack_offset_reg_out == $past(stack_offset_reg_in)
    + ($past(segmented_flag_in) ? 16'h0004 : 16'h0002))
    else $error("call stack step wrong");
  push_step_a: assert property (s_op(8'h11) ##0 segmented_flag_in
    && xfer_count_in == 4'h3 |=> dest_odd_we_out
    && dest_odd_reg_out == $past(dest_odd_reg_in) + 16'h0004)
    else $error("push long step wrong");
  ret_step_a: assert property (s_op(8'h9E) ##0 xfer_count_in == 4'h1
    |=> stack_we_out
    && stack_offset_reg_out == $past(stack_offset_reg_in) - 16'h0004)
    else $error("return step wrong");
  load_program_status_mode_a: assert property (s_op(8'h39) ##0 xfer_count_in == 4'h2
    |=> fcw_we_out && flag_control_word_out == 16'hC000)
    else $error("mode bits not set");
  ldl_addr_a: assert property (s_op(8'h14) ##0 !segmented_flag_in
    && xfer_count_in == 4'h1 |=> dest_we_out
    && dest_reg_out == $past(violation_offset_in) - 16'h0002)
    else $error("load long address wrong");
  quiet_other_a: assert property (s_op(8'h00) |=> done_out
    && !(count_we_out || stack_we_out || dest_we_out || dest_odd_we_out
    || source_we_out || fcw_we_out))
    else $error("write on unhandled opcode");
endmodule
`default_nettype wire

// *** abr_fixup_tb.sv ***
// Self-checking bench for the abort register fix-up block.
// Assumes abr_fixup, abr_mmu_model and the monitor are compiled.
`timescale 1ns/10ps
`default_nettype none

module abr_fixup_tb;
  typedef struct packed
  {
    logic [6:0]  we;
    logic [15:0] c, s, d, o, r, q, f;
  } abr_exp_t;
  logic        core_clk_in, rst_in, ce_in, start_in, restart_in, fault;
  logic        segmented_flag_in, dest_is_addr_reg_in;
  logic [7:0]  opcode_hi_in;
  logic [3:0]  low_opcode_nibble_in, index_sel_in, xfer_count_in, fcnt;
  logic [4:0]  ldm_read_count_in;
  logic [6:0]  violation_segment_in, fseg;
  logic [15:0] violation_offset_in, instruction_offset_in, foff;
  logic [15:0] count_reg_in, stack_offset_reg_in, dest_reg_in;
  logic [15:0] dest_odd_reg_in, source_reg_in, flag_control_word_in;
  logic [15:0] first_status_word_in, count_reg_out, stack_offset_reg_out;
  logic [15:0] dest_reg_out, dest_odd_reg_out, source_reg_out;
  logic [15:0] source_odd_reg_out, flag_control_word_out;
  logic [31:0] source_pair_in;
  logic        count_we_out, stack_we_out, dest_we_out, dest_odd_we_out;
  logic        source_we_out, source_odd_we_out, fcw_we_out;
  logic        done_out, busy_out;
  integer      seed = 32'h8ad50411;
  integer      n_tests = 0;
  integer      n_mismatch = 0;
  logic [3:0]  lns [8] = '{4'h1, 4'h2, 4'h6, 4'h9, 4'hA, 4'hE, 4'h0, 4'h7};

  abr_fixup i_dut
  (
    .core_clk_in, .rst_in, .ce_in, .start_in, .restart_in, .opcode_hi_in,
    .low_opcode_nibble_in, .segmented_flag_in, .dest_is_addr_reg_in,
    .index_sel_in, .ldm_read_count_in, .xfer_count_in,
    .violation_segment_in, .violation_offset_in, .instruction_offset_in,
    .count_reg_in, .stack_offset_reg_in, .dest_reg_in, .dest_odd_reg_in,
    .source_reg_in, .source_pair_in, .flag_control_word_in,
    .first_status_word_in, .count_reg_out, .count_we_out,
    .stack_offset_reg_out, .stack_we_out, .dest_reg_out, .dest_we_out,
    .dest_odd_reg_out, .dest_odd_we_out, .source_reg_out, .source_we_out,
    .source_odd_reg_out, .source_odd_we_out, .flag_control_word_out,
    .fcw_we_out, .done_out, .busy_out
  );
  abr_mmu_model i_mmu
  (
    .core_clk_in, .fault_in(fault), .fault_segment_in(fseg),
    .fault_offset_in(foff), .fault_count_in(fcnt),
    .violation_segment_out(violation_segment_in),
    .violation_offset_out(violation_offset_in),
    .xfer_count_out(xfer_count_in)
  );

  // ==========================================================
  // Expectation and checking
  function automatic abr_exp_t predict();
    abr_exp_t    e;
    logic [15:0] sw, st, lm;
    logic        mis, up, hit, sg;
    logic [3:0]  x, ln;
    e = '0;
    sg = segmented_flag_in;
    x = xfer_count_in;
    ln = low_opcode_nibble_in;
    sw = {1'b0, violation_segment_in, 8'h00};
    st = (opcode_hi_in == 8'hBB) ? 16'h0002 : 16'h0001;
    lm = violation_offset_in - {10'h000, ldm_read_count_in, 1'b0} - 16'h0002;
    mis = sg ? (source_pair_in != {sw, violation_offset_in})
      : (source_reg_in != violation_offset_in);
    up = ln[3];
    hit = (ln == 4'h1 || ln == 4'h9) ? (x == 4'h0)
      : (ln inside {4'h2, 4'h6, 4'hA, 4'hE}) && mis;
    case (opcode_hi_in)
      8'hB8, 8'hBA, 8'hBB:
      begin
        e.we[6] = 1'b1;
        e.c = count_reg_in + 16'h0001;
        e.we[sg ? 3 : 4] = hit && opcode_hi_in != 8'hB8;
        e.d = up ? dest_reg_in + st : dest_reg_in - st;
        e.o = up ? dest_odd_reg_in + st : dest_odd_reg_in - st;
      end
      8'h11, 8'h51:
      begin
        e.we[sg ? 3 : 4] = (x == 4'h3);
        e.d = dest_reg_in + 16'h0004;
        e.o = dest_odd_reg_in + 16'h0004;
      end
      8'h14, 8'h35:
      begin
        e.we[4] = (x == 4'h1);
        e.d = sg ? sw : violation_offset_in - 16'h0002;
      end
      8'h75:
      begin
        e.we[4] = (x == 4'h1) && sg && dest_is_addr_reg_in;
        e.d = sw;
      end
      8'h39:
      begin
        e.we[0] = (x == 4'h1 && flag_control_word_in == first_status_word_in)
          || x == 4'h2;
        e.f = (x == 4'h2) ? 16'hC000 : 16'h4000;
      end
      8'h9E:
      begin
        e.we[5] = (x == 4'h0 && !sg) || x == 4'h1;
        e.s = stack_offset_reg_in - ((x == 4'h1) ? 16'h0004 : 16'h0002);
      end
      8'h10:
      begin
        e.we[2] = 1'b1;
        e.we[1] = sg;
        e.r = sg ? sw : lm;
        e.q = lm;
      end
      8'h50:
      begin
        e.we[2] = (index_sel_in != 4'h0);
        e.r = lm - instruction_offset_in;
      end
      default:
      begin
        e.we[5] = opcode_hi_in[7:4] == 4'hD || opcode_hi_in == 8'h1F
          || opcode_hi_in == 8'h5F;
        e.s = stack_offset_reg_in + (sg ? 16'h0004 : 16'h0002);
      end
    endcase
    return e;
  endfunction

  function automatic logic [15:0] rnd16();
    logic [31:0] t;
    t = $random(seed);
    return t[15:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] ex, got);
    n_tests++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic run_op(input logic [7:0] op, input integer reps);
    abr_exp_t    e;
    logic [15:0] ev [7];
    logic [15:0] gv [7];
    logic [31:0] r;
    logic [15:0] v;
    for (int k = 0; k < reps; k++)
    begin
      @(posedge core_clk_in);
      r = $random(seed);
      v = rnd16();
      {fault, fseg, foff, fcnt} <= {1'b1, r[14:8], v, 2'b00, r[1:0]};
      {opcode_hi_in, low_opcode_nibble_in} <= {op, lns[k % 8]};
      {segmented_flag_in, dest_is_addr_reg_in} <= r[3:2];
      {index_sel_in, ldm_read_count_in} <= {r[7:4], r[20:16]};
      {instruction_offset_in, count_reg_in} <= {rnd16(), rnd16()};
      {stack_offset_reg_in, dest_reg_in} <= {rnd16(), rnd16()};
      dest_odd_reg_in <= rnd16();
      source_reg_in <= r[21] ? v : rnd16();
      source_pair_in <= r[22] ? {1'b0, r[14:8], 8'h00, v} : {2{rnd16()}};
      flag_control_word_in <= v;
      first_status_word_in <= r[23] ? v : rnd16();
      @(posedge core_clk_in);
      fault <= 1'b0;
      start_in <= 1'b1;
      @(posedge core_clk_in);
      #1;
      e = predict();
      ev = '{e.c, e.s, e.d, e.o, e.r, e.q, e.f};
      gv = '{count_reg_out, stack_offset_reg_out, dest_reg_out,
        dest_odd_reg_out, source_reg_out, source_odd_reg_out,
        flag_control_word_out};
      chk("done", 16'h0003, {14'h0000, done_out, busy_out});
      chk("we", {9'h000, e.we}, {9'h000, count_we_out, stack_we_out,
        dest_we_out, dest_odd_we_out, source_we_out, source_odd_we_out,
        fcw_we_out});
      for (int i = 0; i < 7; i++)
        if (e.we[6 - i])
          chk("value", ev[i], gv[i]);
      @(posedge core_clk_in);
      start_in <= 1'b0;
      restart_in <= 1'b1;
      #1;
      chk("refused", 16'h0000, {15'h0000, done_out});
      @(posedge core_clk_in);
      restart_in <= 1'b0;
      #1;
      chk("busy", 16'h0000, {15'h0000, busy_out});
    end
    $display("test op %h ended", op);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog, sequence
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  initial
  begin
    repeat (8000) @(posedge core_clk_in);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {rst_in, ce_in, start_in, restart_in, fault} = 5'h18;
    {opcode_hi_in, low_opcode_nibble_in, segmented_flag_in} = 13'h0000;
    {dest_is_addr_reg_in, index_sel_in, ldm_read_count_in} = 10'h000;
    {fseg, foff, fcnt, instruction_offset_in} = 43'h0;
    {count_reg_in, stack_offset_reg_in, dest_reg_in} = 48'h0;
    {dest_odd_reg_in, source_reg_in, source_pair_in} = 64'h0;
    {flag_control_word_in, first_status_word_in} = 32'h0;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    run_op(8'hB8, 4);
    run_op(8'hBA, 40);
    run_op(8'hBB, 40);
    run_op(8'h1F, 6);
    run_op(8'h5F, 4);
    run_op(8'hD7, 4);
    run_op(8'h11, 16);
    run_op(8'h51, 8);
    run_op(8'h14, 16);
    run_op(8'h35, 8);
    run_op(8'h75, 16);
    run_op(8'h39, 16);
    run_op(8'h9E, 16);
    run_op(8'h10, 8);
    run_op(8'h50, 16);
    run_op(8'h00, 4);
    run_op(8'h54, 4);
    final_report();
  end
endmodule

bind abr_fixup abr_fixup_monitor i_mon
(
  .core_clk_in, .rst_in, .ce_in, .start_in, .restart_in,
  .segmented_flag_in, .opcode_hi_in, .xfer_count_in, .violation_offset_in,
  .count_reg_in, .stack_offset_reg_in, .dest_odd_reg_in, .count_reg_out,
  .stack_offset_reg_out, .dest_reg_out, .dest_odd_reg_out,
  .flag_control_word_out, .count_we_out, .stack_we_out, .dest_we_out,
  .dest_odd_we_out, .source_we_out, .fcw_we_out, .done_out, .busy_out
);
`default_nettype wire

// *** abr_ldm_off.v ***
// Load multiple address rebuild: offset less 2(n+1), optional
// instruction offset. Assumes n is the count of completed reads.
`timescale 1ns/10ps
`default_nettype none
`include "abr_defs.vh"

module abr_ldm_off
(
  // Operands
  input  wire [15:0] violation_offset_in,
  input  wire [15:0] instruction_offset_in,
  input  wire [4:0]  read_count_in,
  input  wire        use_instruction_offset_in,
  // Result
  output wire [15:0] result_out
);

  wire [15:0] span;
  wire [15:0] instruction_offset;

  // =====================================================
  // 2(n+1) and optional instruction offset
  assign span = {10'h000, read_count_in, 1'b0} + `ABR_STEP_TWO;
  assign instruction_offset = use_instruction_offset_in ? instruction_offset_in : `ABR_ZERO16;
  assign result_out = violation_offset_in - instruction_offset - span;

endmodule
`default_nettype wire

// *** abr_mmu_model.sv ***
// Memory management unit model: reports the captured violation.
// Assumes the bench raises fault_in one cycle before start.
`timescale 1ns/10ps
`default_nettype none

module abr_mmu_model
(
  // Clock and fault request
  input  wire logic        core_clk_in,
  input  wire logic        fault_in,
  input  wire logic [6:0]  fault_segment_in,
  input  wire logic [15:0] fault_offset_in,
  input  wire logic [3:0]  fault_count_in,
  // Violation report
  output var  logic [6:0]  violation_segment_out = 7'h00,
  output var  logic [15:0] violation_offset_out = 16'h0000,
  output var  logic [3:0]  xfer_count_out = 4'h0
);
  // Capture before the fix-up and hold until the next fault
  always @(posedge core_clk_in)
    if (fault_in)
    begin
      violation_segment_out <= fault_segment_in;
      violation_offset_out <= fault_offset_in;
      xfer_count_out <= fault_count_in;
    end
endmodule
`default_nettype wire

// *** abr_str_fix.v ***
// String pointer correction selector for byte and word strings.
// Assumes operands come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "abr_defs.vh"

module abr_str_fix
(
  // Decode inputs
  input  wire [3:0]  nibble_in,
  input  wire        write_pending_in,
  input  wire        mismatch_in,
  input  wire        word_in,
  // Correction
  output reg         hit_out,
  output reg         decr_out,
  output wire [15:0] step_out
);

  // =====================================================
  // Step size by operand width
  assign step_out = word_in ? `ABR_STEP_TWO : `ABR_STEP_ONE;

  // =====================================================
  // Direction and condition by nibble
  always @*
  begin
    hit_out  = 1'b0;
    decr_out = 1'b0;
    case (nibble_in)
      `ABR_LN_LD_INC:
      begin
        hit_out  = write_pending_in;
        decr_out = 1'b1;
      end
      `ABR_LN_CP_INC_A, `ABR_LN_CP_INC_B:
      begin
        hit_out  = mismatch_in;
        decr_out = 1'b1;
      end
      `ABR_LN_LD_DEC:
      begin
        hit_out  = write_pending_in;
      end
      `ABR_LN_CP_DEC_A, `ABR_LN_CP_DEC_B:
      begin
        hit_out  = mismatch_in;
      end
      default:
      begin
        hit_out  = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire
